// ---- verilog/ssbc_pkg.sv ----
// Package: register map, resets, field positions and timing for the braking control
`default_nettype none
package ssbc_pkg;
  // Register byte offsets on APB
  localparam logic [7:0] OFF_THRESH   = 8'h00;
  localparam logic [7:0] OFF_HSCORR   = 8'h04;
  localparam logic [7:0] OFF_METHOD   = 8'h08;
  localparam logic [7:0] OFF_DIST     = 8'h0C;
  localparam logic [7:0] OFF_SLCOMP   = 8'h10;
  localparam logic [7:0] OFF_CTRL     = 8'h14;
  localparam logic [7:0] OFF_STATUS   = 8'h18;
  // Reset values
  localparam logic [7:0] RST_THRESH   = 8'h6A;
  localparam logic [7:0] RST_HSCORR   = 8'h0C;
  localparam logic [7:0] RST_METHOD   = 8'h00;
  localparam logic [7:0] RST_DIST     = 8'h00;
  localparam logic [7:0] RST_SLCOMP   = 8'h00;
  localparam logic [7:0] RST_CTRL     = 8'h00;
  // Control register fields
  localparam int CTRL_STOP_RIGHT = 0;
  localparam int CTRL_STOP_LEFT  = 1;
  localparam int CTRL_BASIC_B2   = 2;
  localparam int CTRL_SHUNT_B5   = 3;
  localparam int CTRL_EXT_B6     = 4;
  // Method selector codes
  localparam logic [7:0] MODE_TIME  = 8'h00;
  localparam logic [7:0] MODE_AUTO  = 8'h01;
  localparam logic [7:0] MODE_MAN   = 8'h02;
  localparam logic [7:0] MODE_BOTH  = 8'h03;
  localparam logic [7:0] MODE_AUTOI = 8'h0B;
  localparam logic [7:0] MODE_MANI  = 8'h0C;
  localparam logic [7:0] MODE_BOTHI = 8'h0D;
  // Threshold validity and recognition timing
  localparam logic [7:0] THR_MIN    = 8'h01;
  localparam logic [7:0] THR_MAX    = 8'h0E;
  localparam int         CLK_HZ     = 25_000_000;
  localparam int         NORMAL_MS  = 500;
  localparam int         SLOW_MS    = 1000;
  localparam int         NORMAL_CYC = CLK_HZ / 1000 * NORMAL_MS;
  localparam int         SLOW_CYC   = CLK_HZ / 1000 * SLOW_MS;
  localparam int         FAST_CYC   = 1;
  // Full speed code
  localparam logic [7:0] FULL_SPEED = 8'hFF;

  typedef struct packed {
    logic [7:0] speed;
    logic       stopping;
    logic       detected;
  } ssbc_out_t;
endpackage
`default_nettype wire

// ---- verilog/ssbc_top.sv ----
// Braking control: asymmetry detection, brake sections and distance stops
//
// Operation
// - Hundreds digit selects recognition speed
// - Tens/ones digits give threshold in 0.1 V
// - Asymmetry at threshold triggers a stop
// - Threshold setting resets to 106
// - High-speed correction, default 12
// - Selector 1 auto, 2 manual, 3 both
// - Below full speed hold, then brake
// - Selectors 11-13 brake immediately
// - Selector 0 uses ordinary deceleration time
// - Distance setting scales stopping distance
// - Distance independent of starting speed
// - Manual mode stops on zero command
// - Distance stop only for full stops
// - Recompute travelled distance while stopping
// - Exponential braking curve during distance stop
// - Speed-limit stop compensation, default 0
// - Direction bits enable asymmetric stops
//
// The register addresses and the APB interface to the registers are this design's own decisions.
`default_nettype none
module ssbc_top #(
  parameter int NORMAL_CYCLES = ssbc_pkg::NORMAL_CYC,
  parameter int SLOW_CYCLES   = ssbc_pkg::SLOW_CYC
) (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        clk_en,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic             pready,
  output logic             pslverr,
  output logic      [31:0] prdata,
  input  wire logic [3:0]  half_wave_diff,
  input  wire logic        right_rail_high,
  input  wire logic        dc_brake_section,
  input  wire logic        dc_polarity_match,
  input  wire logic        signal_speed_influence_stop,
  input  wire logic [7:0]  target_speed,
  input  wire logic [7:0]  decel_rate,
  output ssbc_pkg::ssbc_out_t brake_out
);
  // Elaboration checks: slow recognition must never be quicker than normal
  if (NORMAL_CYCLES < 1) begin : g_bad_normal
    $error("ssbc_top: normal recognition interval must be at least one cycle");
  end
  if (SLOW_CYCLES < NORMAL_CYCLES) begin : g_bad_slow
    $error("ssbc_top: slow recognition interval shorter than normal");
  end

  // Configuration registers, one 8-bit field each
  logic [7:0] thresh_q;
  logic [7:0] hscorr_q;
  logic [7:0] method_q;
  logic [7:0] dist_q;
  logic [7:0] slcomp_q;
  logic [7:0] ctrl_q;

  // Pin synchronisers, two flops before any logic
  logic [3:0] diff_s1;
  logic [3:0] diff_s2;
  logic [3:0] pin_s1;
  logic [3:0] pin_s2;

  // Stop sequencer state
  typedef enum logic [1:0] {
    S_RUN,
    S_HOLD,
    S_BRAKE,
    S_STOPPED
  } ssbc_state_t;
  // Speed and distance are abstract units; 16 bits hold setting*256 plus correction
  ssbc_state_t state_q;
  ssbc_state_t state_d;
  logic [7:0]  speed_q;
  logic [7:0]  speed_d;
  logic [31:0] recog_cnt_q;
  logic        detected_q;
  logic [15:0] dist_left_q;
  logic [15:0] dist_left_d;
  logic [15:0] hold_q;
  logic [15:0] hold_d;
  logic [7:0]  tick_q;
  logic [7:0]  target_prev_q;

  // Hundreds and low digits of the threshold setting
  function automatic logic [1:0] hundreds(input logic [7:0] v);
    logic [1:0] h;
    h = 2'd0;
    if (v >= 8'd200)
      h = 2'd2;
    else if (v >= 8'd100)
      h = 2'd1;
    hundreds = h;
  endfunction
  function automatic logic [7:0] low_digits(input logic [7:0] v);
    logic [7:0] r;
    r = v;
    if (v >= 8'd200)
      r = v - 8'd200;
    else if (v >= 8'd100)
      r = v - 8'd100;
    low_digits = r;
  endfunction

  // APB decode: one select per register, shared by read mux and error
  wire sel_thresh = (paddr == ssbc_pkg::OFF_THRESH);
  wire sel_hscorr = (paddr == ssbc_pkg::OFF_HSCORR);
  wire sel_method = (paddr == ssbc_pkg::OFF_METHOD);
  wire sel_dist   = (paddr == ssbc_pkg::OFF_DIST);
  wire sel_slcomp = (paddr == ssbc_pkg::OFF_SLCOMP);
  wire sel_ctrl   = (paddr == ssbc_pkg::OFF_CTRL);
  wire sel_status = (paddr == ssbc_pkg::OFF_STATUS);
  // Writes land at the access edge only when clk_en is high
  wire apb_wr    = psel && penable && pwrite && clk_en;
  wire hit_known = sel_thresh || sel_hscorr || sel_method || sel_dist ||
                   sel_slcomp || sel_ctrl || sel_status;
  // Zero wait states: every access completes in its first access cycle
  assign pready  = 1'b1;
  assign pslverr = psel && penable && !hit_known;

  // Recognition digits; settings outside 1..14 tenths leave detection off
  // rather than guessing, so a mistyped value never stops a train
  wire [1:0] sens_digit = hundreds(thresh_q);
  wire [7:0] thr_tenths = low_digits(thresh_q);
  wire       thr_valid  = (thr_tenths >= ssbc_pkg::THR_MIN) && (thr_tenths <= ssbc_pkg::THR_MAX);
  wire [31:0] recog_len = (sens_digit == 2'd2) ? SLOW_CYCLES :
                          (sens_digit == 2'd1) ? NORMAL_CYCLES : ssbc_pkg::FAST_CYC;

  // Asymmetry at or above threshold, gated by direction enables
  wire over_thr   = thr_valid && ({4'h0, diff_s2} >= thr_tenths);
  wire dir_ok     = (ctrl_q[ssbc_pkg::CTRL_STOP_RIGHT] && pin_s2[0]) ||
                    (ctrl_q[ssbc_pkg::CTRL_STOP_LEFT] && !pin_s2[0]);
  wire asym_cond  = over_thr && dir_ok;

  // DC brake section reactions need the configurer's bits
  // Polarity-free sections skip the polarity match when the extended bit is set
  wire dc_cfg     = !ctrl_q[ssbc_pkg::CTRL_BASIC_B2] && ctrl_q[ssbc_pkg::CTRL_SHUNT_B5];
  wire dc_stop    = dc_cfg && pin_s2[1] &&
                    (pin_s2[2] || ctrl_q[ssbc_pkg::CTRL_EXT_B6]);

  // Mode decoding
  // Immediate variants share the auto/manual split of the plain codes
  wire mode_auto  = (method_q == ssbc_pkg::MODE_AUTO) || (method_q == ssbc_pkg::MODE_BOTH) ||
                    (method_q == ssbc_pkg::MODE_AUTOI) || (method_q == ssbc_pkg::MODE_BOTHI);
  wire mode_man   = (method_q == ssbc_pkg::MODE_MAN) || (method_q == ssbc_pkg::MODE_BOTH) ||
                    (method_q == ssbc_pkg::MODE_MANI) || (method_q == ssbc_pkg::MODE_BOTHI);
  wire mode_imm   = (method_q >= ssbc_pkg::MODE_AUTOI) && (method_q <= ssbc_pkg::MODE_BOTHI);
  wire auto_trig  = detected_q || dc_stop || pin_s2[3];
  // Manual stop: commanded speed falls to zero
  wire man_trig   = (target_speed == 8'h00) && (target_prev_q != 8'h00);
  wire dist_start = (mode_auto && auto_trig) || (mode_man && man_trig);

  // Stopping distance: setting scaled, plus correction terms
  // Product kept at 16 bits so its high byte survives the scaling
  wire [15:0] corr_prod   = hscorr_q * speed_q;
  wire [15:0] dist_raw    = {dist_q, 8'h00} + {8'h00, corr_prod[15:8]};
  // Compensation larger than the distance would wrap, so it saturates at zero
  wire [15:0] dist_target = (dist_raw > {8'h00, slcomp_q}) ? dist_raw - {8'h00, slcomp_q} : 16'h0000;

  // Speed controller cadence: one step every 256 cycles
  wire        tick_due  = (tick_q == 8'h00);
  // Time-constant braking step, floored at standstill
  wire [7:0]  time_step = (speed_q > decel_rate) ? speed_q - decel_rate : 8'h00;
  // Hold length grows as entry speed falls, so the brake point moves closer
  // Hold time for slower entry: distance shortfall against full-speed braking
  wire [15:0] hold_len = {8'h00, ssbc_pkg::FULL_SPEED - speed_q};
  // Exponential step: proportional to current speed, at least one
  wire [7:0]  exp_step = (speed_q >> 3) | 8'h01;

  // Sequencer next state
  // Distance stops run only from motion; a standing train starts no distance stop
  always_comb begin
    state_d     = state_q;
    speed_d     = speed_q;
    dist_left_d = dist_left_q;
    hold_d      = hold_q;
    case (state_q)
      S_RUN: begin
        if (dist_start && speed_q != 8'h00) begin
          dist_left_d = dist_target;
          hold_d      = mode_imm ? 16'h0000 : hold_len;
          state_d     = mode_imm ? S_BRAKE : S_HOLD;
        end else if (auto_trig && !mode_auto) begin
          // Time-constant braking at ordinary rate
          speed_d = time_step;
        end else if (tick_due) begin
          // Accelerations and partial reductions follow the speed controller
          speed_d = target_speed;
        end
      end
      S_HOLD: begin
        // Entry speed is kept, then braking runs at the full-speed rate
        if (hold_q == 16'h0000)
          state_d = S_BRAKE;
        else
          hold_d = hold_q - 16'h0001;
      end
      S_BRAKE: begin
        if (tick_due) begin
          // Recompute remaining distance and pick a step from it
          dist_left_d = (dist_left_q > {8'h00, speed_q}) ? dist_left_q - {8'h00, speed_q} : 16'h0000;
          if (dist_left_d == 16'h0000 || speed_q <= exp_step)
            speed_d = 8'h00;
          else if (dist_left_d[15:8] < speed_q)
            speed_d = speed_q - (exp_step << 1);
          else
            speed_d = speed_q - exp_step;
        end
        if (speed_q == 8'h00)
          state_d = S_STOPPED;
      end
      S_STOPPED: begin
        // Leave only once the trigger is gone and a speed is commanded
        if (!auto_trig && target_speed != 8'h00)
          state_d = S_RUN;
      end
      default: state_d = S_RUN;
    endcase
  end

  // Configuration registers; writes are lost while the clock enable is low
  // CTRL keeps only its five defined bits
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      thresh_q <= ssbc_pkg::RST_THRESH;
      hscorr_q <= ssbc_pkg::RST_HSCORR;
      method_q <= ssbc_pkg::RST_METHOD;
      dist_q   <= ssbc_pkg::RST_DIST;
      slcomp_q <= ssbc_pkg::RST_SLCOMP;
      ctrl_q   <= ssbc_pkg::RST_CTRL;
    end else if (apb_wr) begin
      case (paddr)
        ssbc_pkg::OFF_THRESH: thresh_q <= pwdata[7:0];
        ssbc_pkg::OFF_HSCORR: hscorr_q <= pwdata[7:0];
        ssbc_pkg::OFF_METHOD: method_q <= pwdata[7:0];
        ssbc_pkg::OFF_DIST:   dist_q   <= pwdata[7:0];
        ssbc_pkg::OFF_SLCOMP: slcomp_q <= pwdata[7:0];
        ssbc_pkg::OFF_CTRL:   ctrl_q   <= {3'b000, pwdata[4:0]};
        default: ;
      endcase
    end
  end

  // Asymmetry level passes two flops
  // Track pickup is asynchronous to pclk
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      diff_s1 <= 4'h0;
      diff_s2 <= 4'h0;
    end else if (clk_en) begin
      diff_s1 <= half_wave_diff;
      diff_s2 <= diff_s1;
    end
  end

  // Rail and section pins pass two flops
  // Only the second flop feeds any logic
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_s1 <= 4'h0;
      pin_s2 <= 4'h0;
    end else if (clk_en) begin
      pin_s1 <= {signal_speed_influence_stop, dc_polarity_match, dc_brake_section, right_rail_high};
      pin_s2 <= pin_s1;
    end
  end

  // Persistence counter, restarts whenever the condition drops
  // One noisy cycle restarts the count: latency traded for fewer false stops
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      recog_cnt_q <= 32'h0000_0000;
      detected_q  <= 1'b0;
    end else if (clk_en) begin
      if (!asym_cond) begin
        recog_cnt_q <= 32'h0000_0000;
        detected_q  <= 1'b0;
      end else if (recog_cnt_q + 32'h0000_0001 >= recog_len) begin
        detected_q  <= 1'b1;
      end else begin
        recog_cnt_q <= recog_cnt_q + 32'h0000_0001;
      end
    end
  end

  // Sequencer state; speed updates every 256 cycles, except time-constant braking, which steps every cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q     <= S_RUN;
      speed_q     <= 8'h00;
      dist_left_q <= 16'h0000;
      hold_q      <= 16'h0000;
    end else if (clk_en) begin
      state_q     <= state_d;
      speed_q     <= speed_d;
      dist_left_q <= dist_left_d;
      hold_q      <= hold_d;
    end
  end

  // Cadence counter and last commanded speed for the zero test
  // Free-running, frozen with everything else when clk_en is low
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tick_q        <= 8'h00;
      target_prev_q <= 8'h00;
    end else if (clk_en) begin
      tick_q        <= tick_q + 8'h01;
      target_prev_q <= target_speed;
    end
  end

  // Stopping flag covers the hold and brake phases of a distance stop
  wire stopping_d = (state_d == S_HOLD) || (state_d == S_BRAKE);

  // Outputs from flops
  // Speed and stopping fed from next-state values so speed never lags the sequencer
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn)
      brake_out <= '0;
    else if (clk_en) begin
      brake_out.speed    <= speed_d;
      brake_out.stopping <= stopping_d;
      brake_out.detected <= detected_q;
    end
  end

  // Read mux, settings in the low byte, status in the low two bytes; status shows the registered flag seen on brake_out
  // Unmapped offsets read zero through the and-or structure
  wire [31:0] status_word = {16'h0000, speed_q, 4'h0, brake_out.detected, dc_stop, state_q};
  assign prdata = ({32{sel_thresh}} & {24'h00_0000, thresh_q}) |
                  ({32{sel_hscorr}} & {24'h00_0000, hscorr_q}) |
                  ({32{sel_method}} & {24'h00_0000, method_q}) |
                  ({32{sel_dist}}   & {24'h00_0000, dist_q}) |
                  ({32{sel_slcomp}} & {24'h00_0000, slcomp_q}) |
                  ({32{sel_ctrl}}   & {24'h00_0000, ctrl_q}) |
                  ({32{sel_status}} & status_word);
endmodule
`default_nettype wire

// ---- verif/ssbc_cmd_station.sv ----
// Command station model: track signal half waves and rail polarity
`default_nettype none
module ssbc_cmd_station (
  input  wire logic       asym_on,
  input  wire logic [3:0] amp,
  input  wire logic       rail_right,
  output logic [3:0]      half_wave_diff,
  output logic            right_rail_high,
  output logic            dc_brake_section,
  output logic            dc_polarity_match,
  output logic            sl_stop
);
  // Symmetric signal outside stop sections, so no stale asymmetry lingers
  assign half_wave_diff    = asym_on ? amp : 4'h0;
  assign right_rail_high   = rail_right;
  // Plain digital track: no DC sections, no signal-speed stops
  assign dc_brake_section  = 1'b0;
  assign dc_polarity_match = 1'b0;
  assign sl_stop           = 1'b0;
endmodule
`default_nettype wire

// ---- verif/ssbc_checker.sv ----
// Checker: register bus and brake output relations of the braking control
`default_nettype none
module ssbc_checker #(
  parameter int NORMAL_CYCLES = 20,
  parameter int SLOW_CYCLES   = 40
) (
  input wire logic                pclk,
  input wire logic                presetn,
  input wire logic                clk_en,
  input wire logic                psel,
  input wire logic                penable,
  input wire logic                pwrite,
  input wire logic [7:0]          paddr,
  input wire logic                pready,
  input wire logic                pslverr,
  input wire logic [31:0]         prdata,
  input wire ssbc_pkg::ssbc_out_t brake_out
);
  // Decode mirrors the register map; misaligned offsets count as unmapped
  wire logic unm = (paddr[1:0] != 2'b00) || (paddr > ssbc_pkg::OFF_STATUS);
  wire logic rd  = psel && penable && !pwrite;
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  a_ready_access: assert property (psel && penable |-> pready) else $error("pready low in access");
  a_slverr_decode: assert property (psel && penable |-> pslverr == unm) else $error("pslverr wrong");
  a_unmapped_zero: assert property (rd && unm |-> prdata == 32'h0000_0000) else $error("unmapped read not 0");
  a_narrow_fields: assert property (rd && !unm && paddr < ssbc_pkg::OFF_CTRL |-> prdata[31:8] == '0)
    else $error("setting wider than 8 bits");
  a_ctrl_width: assert property (rd && paddr == ssbc_pkg::OFF_CTRL |-> prdata[31:5] == '0)
    else $error("control wider than 5 bits");
  a_status_mirror: assert property (rd && paddr == ssbc_pkg::OFF_STATUS |->
    prdata[15:8] == brake_out.speed && prdata[3] == brake_out.detected) else $error("status mismatch");
  a_reset_clear: assert property ($rose(presetn) |-> brake_out == '0) else $error("brake output not clear");
  a_freeze_hold: assert property (!clk_en |=> $stable(brake_out)) else $error("output moved while frozen");
  a_stop_monotone: assert property (brake_out.stopping && $past(brake_out.stopping) |->
    brake_out.speed <= $past(brake_out.speed)) else $error("speed rose while stopping");
endmodule
bind ssbc_top ssbc_checker #(.NORMAL_CYCLES(NORMAL_CYCLES), .SLOW_CYCLES(SLOW_CYCLES)) ssbc_checker_i (
  .pclk(pclk), .presetn(presetn), .clk_en(clk_en), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pready(pready), .pslverr(pslverr), .prdata(prdata), .brake_out(brake_out));
`default_nettype wire

// ---- verif/ssbc_top_tb.sv ----
// Testbench: register map, write freeze and asymmetry recognition
`default_nettype none
module ssbc_top_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic                pclk = 0, presetn = 0, clk_en = 1, psel = 0, penable = 0, pwrite = 0;
  logic [7:0]          paddr = '0, tspd = '0, drate = '0;
  logic [31:0]         pwdata = '0, prdata, seed = 32'h077b_05cf;
  logic                pready, pslverr, rail = 1, asym_on = 0;
  logic [3:0]          hwd, amp = 4'h6;
  logic                rrh, dcb, dcp, sls;
  ssbc_pkg::ssbc_out_t bo;
  int                  mismatches = 0, num_checks = 0;
  int                  exp_reg [7];
  int                  mask [7] = '{255, 255, 255, 255, 255, 31, 0};
  ssbc_top #(.NORMAL_CYCLES(20), .SLOW_CYCLES(40)) ssbc_top_i (.pclk(pclk), .presetn(presetn), .clk_en(clk_en),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
    .pslverr(pslverr), .prdata(prdata), .half_wave_diff(hwd), .right_rail_high(rrh), .dc_brake_section(dcb),
    .dc_polarity_match(dcp), .signal_speed_influence_stop(sls), .target_speed(tspd), .decel_rate(drate),
    .brake_out(bo));
  ssbc_cmd_station ssbc_cmd_station_i (.asym_on(asym_on), .amp(amp), .rail_right(rail), .half_wave_diff(hwd),
    .right_rail_high(rrh), .dc_brake_section(dcb), .dc_polarity_match(dcp), .sl_stop(sls));
  initial forever #20 pclk = ~pclk;
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  task automatic chk(input string what, input logic [31:0] e, input logic [31:0] g);
    num_checks++;
    if (g !== e) begin
      $display("[FAIL] %s expected %h seen %h", what, e, g);
      mismatches++;
    end
  endtask
  // One APB transfer; holds everything until pready is seen high
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r,
                     output logic e);
    int n;
    @(posedge pclk);
    psel    <= 1'b1;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 16);
    r = prdata;
    e = pslverr;
    if (n >= 16) begin
      mismatches++;
      report_and_stop;
    end
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask
  // Model follows only mapped writes made while the clock enable is high
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic        e;
    apb(1'b1, a, d, r, e);
    if (clk_en === 1'b1 && a[1:0] == 2'b00 && a < 8'h18) exp_reg[a[4:2]] = d & mask[a[4:2]];
  endtask
  task automatic rd(input logic [7:0] a);
    logic [31:0] r;
    logic        e;
    logic        u;
    u = a[1:0] != 2'b00 || a > 8'h18;
    apb(1'b0, a, 32'h0, r, e);
    chk("pslverr", {31'h0, u}, {31'h0, e});
    if (a != 8'h18) chk("prdata", u ? 32'h0 : exp_reg[a[4:2]], r);
  endtask
  task automatic do_reset;
    presetn <= 1'b0;
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    exp_reg = '{106, 12, 0, 0, 0, 0, 0};
  endtask
  // Asymmetry case: quiet until lo cycles, then detection as expected
  task automatic det(input logic [7:0] thr, input logic [4:0] ctl, input logic [3:0] a, input int lo,
                     input logic ex);
    int n;
    do_reset;
    wr(8'h00, {24'h0, thr});
    wr(8'h14, {27'h0, ctl});
    amp     <= a;
    asym_on <= 1'b1;
    repeat (lo) @(posedge pclk);
    #1;
    chk("detected early", 32'h0, {31'h0, bo.detected});
    for (n = 0; n < 24 && bo.detected !== ex; n++) @(posedge pclk);
    #1;
    chk("detected", {31'h0, ex}, {31'h0, bo.detected});
    asym_on <= 1'b0;
    $display("asymmetry case %0d done", thr);
  endtask
  // Stop case: cruise, trigger by asymmetry or zero command, wait for standstill
  task automatic brk(input logic [7:0] m, input logic cmd, input logic ex_stop);
    int          n;
    logic        seen;
    logic [31:0] r;
    logic        e;
    tspd  <= 8'h40;
    drate <= 8'h08;
    do_reset;
    wr(8'h08, {24'h0, m});
    wr(8'h14, 32'h9);
    repeat (600) @(posedge pclk);
    #1;
    chk("cruise speed", 32'h40, {24'h0, bo.speed});
    @(posedge pclk);
    if (cmd) tspd <= 8'h00;
    else asym_on <= 1'b1;
    seen = 1'b0;
    for (n = 0; n < 20000 && bo.speed !== 8'h00; n++) begin
      @(posedge pclk);
      if (bo.stopping === 1'b1) seen = 1'b1;
    end
    #1;
    chk("standstill", 32'h0, {24'h0, bo.speed});
    chk("distance stop used", {31'h0, ex_stop}, {31'h0, seen});
    apb(1'b0, 8'h18, 32'h0, r, e);
    chk("stop state", ex_stop ? 32'h3 : 32'h0, {30'h0, r[1:0]});
    asym_on <= 1'b0;
    $display("stop case method %0d done", m);
  endtask
  initial begin
    int modes [7] = '{0, 1, 2, 3, 11, 12, 13};
    do_reset;
    for (int i = 0; i < 8; i++) rd(8'(i * 4));
    for (int i = 0; i < 6; i++) begin
      seed = lfsr(seed);
      wr(8'(i * 4), seed);
      rd(8'(i * 4));
    end
    wr(8'h1c, seed);
    rd(8'h02);
    foreach (modes[i]) begin
      wr(8'h08, modes[i]);
      rd(8'h08);
    end
    tspd    <= seed[7:0];
    drate   <= seed[15:8];
    clk_en  <= 1'b0;
    wr(8'h00, 32'h55);
    clk_en  <= 1'b1;
    rd(8'h00);
    $display("register map done");
    det(8'h6a, 5'h09, 4'h6, 18, 1'b1);
    det(8'hce, 5'h19, 4'h7, 38, 1'b1);
    det(8'h72, 5'h0b, 4'he, 0, 1'b1);
    det(8'h6a, 5'h09, 4'h5, 30, 1'b0);
    det(8'h6a, 5'h0a, 4'h7, 30, 1'b0);
    do_reset;
    wr(8'h14, 32'h9);
    asym_on <= 1'b1;
    repeat (12) @(posedge pclk);
    asym_on <= 1'b0;
    @(posedge pclk);
    asym_on <= 1'b1;
    repeat (17) @(posedge pclk);
    #1;
    chk("restarted interval", 32'h0, {31'h0, bo.detected});
    asym_on <= 1'b0;
    $display("restart case done");
    brk(8'h00, 1'b0, 1'b0);
    brk(8'h01, 1'b0, 1'b1);
    brk(8'h0b, 1'b0, 1'b1);
    brk(8'h0c, 1'b1, 1'b1);
    report_and_stop;
  end
  initial begin
    repeat (100000) @(posedge pclk);
    mismatches++;
    report_and_stop;
  end
endmodule
`default_nettype wire
